// >>> verilog/lfm_fault_regs.sv
// fault flags, live fault status, masks and open-drain interrupt of the regulator controller
// assumes fault inputs are levels synchronous to mclk and i2c runs well below mclk/4
//
// Overview of operation
// - flags held until read or enable pin low
// - undervoltage status per enabled channel, bit7 zero
// - overcurrent status per enabled channel, bit7 zero
// - bit 7 shows thermal shutdown
// - bit 6 shows thermal warning
// - bit 5 shows system supply lockout
// - bits 4-2 show gated input lockouts
// - bit 1 shows rail lockout, channel 3/4
// - bit 0 shows rail lockout, channel 1/2
// - suspend bit 7 shows whole-chip suspension
// - suspend bits 6-0 show per-channel suspension
// - undervoltage mask bits block interrupt pin
// - undervoltage mask resets to zero
// - undervoltage status resets to zero
// - overcurrent status resets to zero
// - suspend status resets to zero
// - overcurrent mask at 0x1D, resets zero
// - overcurrent mask bits block interrupt pin
// - suspend from input lockout, overcurrent, undervoltage
`include "lfm_map.svh"

module lfm_fault_regs #(
  parameter int         CH_COUNT = `LFM_CH_COUNT,
  parameter logic [6:0] DEV_ADDR = `LFM_I2C_ADDR_DEFAULT
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       ctrl_enable_b,
  input  wire logic [6:0] ch_enabled,
  input  wire logic [6:0] ch_undervolt,
  input  wire logic [6:0] ch_overcurrent,
  input  wire logic       rail_a_low,
  input  wire logic       rail_b_low,
  input  wire logic       rail_c_low,
  input  wire logic       rail_d_low,
  input  wire logic       ch7_rail_low,
  input  wire logic       vsys_low,
  input  wire logic       therm_shutdown,
  input  wire logic       therm_warning,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            fault_irq_pin_low_out,
  output logic            fault_irq_pin_low_oe
);
  import lfm_pkg::*;

  generate
    if (CH_COUNT != `LFM_CH_COUNT) begin : g_bad_count
      $error("lfm_fault_regs serves exactly seven channels");
    end
  endgenerate

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta, rst_sync;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ****************************************************************
  // register port
  // ****************************************************************
  logic      wr_stb, rd_stb;
  lfm_byte_t reg_addr, wr_data;
  lfm_byte_t rd_data;

  lfm_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .mclk     (mclk),
    .rst_b    (rst_sync),
    .ce       (ce),
    .scl      (scl),
    .sda_in   (sda_in),
    .sda_oe   (sda_oe),
    .wr_stb   (wr_stb),
    .rd_stb   (rd_stb),
    .reg_addr (reg_addr),
    .wr_data  (wr_data),
    .rd_data  (rd_data)
  );

  // ****************************************************************
  // live status
  // ****************************************************************
  logic [6:0] uv_status, next_uv_status;
  logic [6:0] oc_status, next_oc_status;
  lfm_byte_t  therm_status, next_therm_status;
  lfm_byte_t  susp_status, next_susp_status;
  logic [6:0] ch_input_low;

  // input rail feeding each channel
  assign ch_input_low = {ch7_rail_low, rail_d_low, rail_c_low, rail_b_low, rail_b_low,
                         rail_a_low, rail_a_low};

  always_comb begin
    next_uv_status = ch_undervolt & ch_enabled;
    next_oc_status = ch_overcurrent & ch_enabled;
    next_therm_status = `LFM_RST_BYTE;
    next_therm_status[`LFM_TL_TSD_BIT]    = therm_shutdown;
    next_therm_status[`LFM_TL_WARN_BIT]   = therm_warning;
    next_therm_status[`LFM_TL_VSYS_BIT]   = vsys_low;
    next_therm_status[`LFM_TL_CH7_BIT]    = ch7_rail_low & ch_enabled[6];
    next_therm_status[`LFM_TL_RAIL_D_BIT] = rail_d_low & ch_enabled[5];
    next_therm_status[`LFM_TL_RAIL_C_BIT] = rail_c_low & ch_enabled[4];
    next_therm_status[`LFM_TL_RAIL_B_BIT] = rail_b_low & (ch_enabled[2] | ch_enabled[3]);
    next_therm_status[`LFM_TL_RAIL_A_BIT] = rail_a_low & (ch_enabled[0] | ch_enabled[1]);
    next_susp_status = `LFM_RST_BYTE;
    next_susp_status[6:0] = (ch_input_low & ch_enabled) | next_uv_status |
                            next_oc_status;
    next_susp_status[`LFM_SUSP_CHIP_BIT] = therm_shutdown | vsys_low;
  end

  always_ff @(posedge mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      uv_status    <= `LFM_RST_CH;
      oc_status    <= `LFM_RST_CH;
      therm_status <= `LFM_RST_BYTE;
      susp_status  <= `LFM_RST_BYTE;
    end else if (ce) begin
      uv_status    <= next_uv_status;
      oc_status    <= next_oc_status;
      therm_status <= next_therm_status;
      susp_status  <= next_susp_status;
    end
  end

  // ****************************************************************
  // sticky rail lockout flags
  // ****************************************************************
  logic [3:0] lock_flags, next_lock_flags;
  logic [3:0] rail_prev, rail_now;
  logic       flag_clear;

  assign rail_now = {rail_d_low, rail_c_low, rail_b_low, rail_a_low};

  always_comb begin
    flag_clear = !ctrl_enable_b || (rd_stb && reg_addr == `LFM_OFS_LOCK_FLAGS);
    // a new edge in the clearing cycle still sets the flag
    next_lock_flags = (rail_now ^ rail_prev) | (lock_flags & ~{4{flag_clear}});
  end

  always_ff @(posedge mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      lock_flags <= `LFM_RST_FLAGS;
      rail_prev  <= `LFM_RST_FLAGS;
    end else if (ce) begin
      lock_flags <= next_lock_flags;
      rail_prev  <= rail_now;
    end
  end

  // ****************************************************************
  // masks
  // ****************************************************************
  logic [6:0] uv_mask, next_uv_mask;
  logic [6:0] oc_mask, next_oc_mask;

  always_comb begin
    next_uv_mask = uv_mask;
    next_oc_mask = oc_mask;
    if (wr_stb && reg_addr == `LFM_OFS_UV_MASK) begin
      next_uv_mask = wr_data[6:0];
    end
    if (wr_stb && reg_addr == `LFM_OFS_OC_MASK) begin
      next_oc_mask = wr_data[6:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      uv_mask <= `LFM_RST_CH;
      oc_mask <= `LFM_RST_CH;
    end else if (ce) begin
      uv_mask <= next_uv_mask;
      oc_mask <= next_oc_mask;
    end
  end

  // ****************************************************************
  // readback
  // ****************************************************************
  always_comb begin
    rd_data = `LFM_RST_BYTE;
    case (reg_addr)
      `LFM_OFS_LOCK_FLAGS:   rd_data[3:0] = lock_flags;
      `LFM_OFS_UV_STATUS:    rd_data[6:0] = uv_status;
      `LFM_OFS_OC_STATUS:    rd_data[6:0] = oc_status;
      `LFM_OFS_THERM_STATUS: rd_data      = therm_status;
      `LFM_OFS_SUSP_STATUS:  rd_data      = susp_status;
      `LFM_OFS_UV_MASK:      rd_data[6:0] = uv_mask;
      `LFM_OFS_OC_MASK:      rd_data[6:0] = oc_mask;
      default:               rd_data      = `LFM_RST_BYTE;
    endcase
  end

  // ****************************************************************
  // open-drain pins
  // ****************************************************************
  logic next_irq_oe;

  always_comb begin
    next_irq_oe = (|lock_flags) | (|(uv_status & ~uv_mask))
                | (|(oc_status & ~oc_mask));
  end

  always_ff @(posedge mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      fault_irq_pin_low_oe  <= 1'b0;
      fault_irq_pin_low_out <= 1'b0;
      sda_out               <= 1'b0;
    end else if (ce) begin
      fault_irq_pin_low_oe  <= next_irq_oe;
      fault_irq_pin_low_out <= 1'b0;
      sda_out               <= 1'b0;
    end
  end

endmodule

// >>> pkg/lfm_map.svh
// register offsets, reset values, field positions and bus constants of the fault block
// assumes inclusion by bare name from design files; definitions only
`ifndef LFM_MAP_SVH
`define LFM_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define LFM_OFS_LOCK_FLAGS   8'h17
`define LFM_OFS_UV_STATUS    8'h18
`define LFM_OFS_OC_STATUS    8'h19
`define LFM_OFS_THERM_STATUS 8'h1A
`define LFM_OFS_SUSP_STATUS  8'h1B
`define LFM_OFS_UV_MASK      8'h1C
`define LFM_OFS_OC_MASK      8'h1D

// ****************************************************************
// reset values
// ****************************************************************
`define LFM_RST_BYTE         8'h00
`define LFM_RST_FLAGS        4'h0
`define LFM_RST_CH           7'h00
`define LFM_RST_CNT          4'h0

// ****************************************************************
// field positions of the thermal and lockout status and of the suspend status
// ****************************************************************
`define LFM_TL_TSD_BIT       7
`define LFM_TL_WARN_BIT      6
`define LFM_TL_VSYS_BIT      5
`define LFM_TL_CH7_BIT       4
`define LFM_TL_RAIL_D_BIT    3
`define LFM_TL_RAIL_C_BIT    2
`define LFM_TL_RAIL_B_BIT    1
`define LFM_TL_RAIL_A_BIT    0
`define LFM_SUSP_CHIP_BIT    7

// ****************************************************************
// bus constants and channel count
// ****************************************************************
`define LFM_I2C_ADDR_DEFAULT 7'h35
`define LFM_BITS_PER_BYTE    4'h8
`define LFM_LAST_BIT         4'h7
`define LFM_CH_COUNT         7

`endif

// >>> pkg/lfm_pkg.sv
// types shared by the fault block and its serial register port
// assumes nothing beyond a SystemVerilog compiler
package lfm_pkg;

  typedef logic [7:0] lfm_byte_t;

  typedef enum logic [3:0] {
    LFM_I2C_IDLE    = 4'h0,
    LFM_I2C_DEVADDR = 4'h1,
    LFM_I2C_DEVACK  = 4'h2,
    LFM_I2C_REGADDR = 4'h3,
    LFM_I2C_REGACK  = 4'h4,
    LFM_I2C_WDATA   = 4'h5,
    LFM_I2C_WACK    = 4'h6,
    LFM_I2C_RDATA   = 4'h7,
    LFM_I2C_RACK    = 4'h8
  } lfm_i2c_state_e;

endpackage

// >>> verilog/lfm_i2c_slave.sv
// i2c target that turns bus traffic into register read and write strobes
// assumes scl and sda_in synchronous to mclk and oversampled; reset already synchronised
`include "lfm_map.svh"

module lfm_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = `LFM_I2C_ADDR_DEFAULT
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic              scl,
  input  wire logic              sda_in,
  output logic                   sda_oe,
  output logic                   wr_stb,
  output logic                   rd_stb,
  output lfm_pkg::lfm_byte_t     reg_addr,
  output lfm_pkg::lfm_byte_t     wr_data,
  input  wire lfm_pkg::lfm_byte_t rd_data
);
  import lfm_pkg::*;

  lfm_i2c_state_e state, next_state;
  logic [3:0]     cnt, next_cnt;
  lfm_byte_t      shreg, next_shreg;
  lfm_byte_t      next_reg_addr, next_wr_data;
  logic           is_read, next_is_read;
  logic           next_sda_oe, next_wr_stb, next_rd_stb;
  logic           scl_q, sda_q;
  logic           scl_rise, scl_fall, start_cond, stop_cond, byte_done;

  assign scl_rise   = scl & ~scl_q;
  assign scl_fall   = ~scl & scl_q;
  assign start_cond = scl & scl_q & sda_q & ~sda_in;
  assign stop_cond  = scl & scl_q & ~sda_q & sda_in;
  assign byte_done  = scl_fall && (cnt == `LFM_BITS_PER_BYTE);

  // ****************************************************************
  // bus sequencer
  // ****************************************************************
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_shreg    = shreg;
    next_reg_addr = reg_addr;
    next_wr_data  = wr_data;
    next_is_read  = is_read;
    next_sda_oe   = sda_oe;
    next_wr_stb   = 1'b0;
    next_rd_stb   = 1'b0;
    if (start_cond) begin
      next_state  = LFM_I2C_DEVADDR;
      next_cnt    = `LFM_RST_CNT;
      next_sda_oe = 1'b0;
    end else if (stop_cond) begin
      next_state  = LFM_I2C_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      if (scl_rise && (state == LFM_I2C_DEVADDR || state == LFM_I2C_REGADDR ||
                       state == LFM_I2C_WDATA)) begin
        next_shreg = {shreg[6:0], sda_in};
        next_cnt   = cnt + 4'h1;
      end
      case (state)
        LFM_I2C_DEVADDR: begin
          if (byte_done) begin
            if (shreg[7:1] == DEV_ADDR) begin
              next_is_read = shreg[0];
              next_sda_oe  = 1'b1;
              next_state   = LFM_I2C_DEVACK;
            end else begin
              next_state = LFM_I2C_IDLE;
            end
          end
        end
        LFM_I2C_DEVACK: begin
          if (scl_fall) begin
            next_cnt = `LFM_RST_CNT;
            if (is_read) begin
              next_shreg  = rd_data;
              next_rd_stb = 1'b1;
              next_sda_oe = ~rd_data[7];
              next_state  = LFM_I2C_RDATA;
            end else begin
              next_sda_oe = 1'b0;
              next_state  = LFM_I2C_REGADDR;
            end
          end
        end
        LFM_I2C_REGADDR: begin
          if (byte_done) begin
            next_reg_addr = shreg;
            next_sda_oe   = 1'b1;
            next_state    = LFM_I2C_REGACK;
          end
        end
        LFM_I2C_REGACK, LFM_I2C_WACK: begin
          if (scl_fall) begin
            if (state == LFM_I2C_WACK) begin
              next_reg_addr = reg_addr + 8'h01;
            end
            next_sda_oe = 1'b0;
            next_cnt    = `LFM_RST_CNT;
            next_state  = LFM_I2C_WDATA;
          end
        end
        LFM_I2C_WDATA: begin
          if (byte_done) begin
            next_wr_data = shreg;
            next_wr_stb  = 1'b1;
            next_sda_oe  = 1'b1;
            next_state   = LFM_I2C_WACK;
          end
        end
        LFM_I2C_RDATA: begin
          if (scl_fall) begin
            if (cnt == `LFM_LAST_BIT) begin
              next_sda_oe = 1'b0;
              next_cnt    = `LFM_RST_CNT;
              next_state  = LFM_I2C_RACK;
            end else begin
              next_cnt    = cnt + 4'h1;
              next_shreg  = {shreg[6:0], 1'b0};
              next_sda_oe = ~shreg[6];
            end
          end
        end
        LFM_I2C_RACK: begin
          // controller ack moves to the next register; nack ends the burst
          if (scl_rise) begin
            if (sda_in) begin
              next_state = LFM_I2C_IDLE;
            end else begin
              next_reg_addr = reg_addr + 8'h01;
            end
          end else if (scl_fall) begin
            next_shreg  = rd_data;
            next_rd_stb = 1'b1;
            next_sda_oe = ~rd_data[7];
            next_state  = LFM_I2C_RDATA;
          end
        end
        default: begin
          next_state = LFM_I2C_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= LFM_I2C_IDLE;
      cnt      <= `LFM_RST_CNT;
      shreg    <= `LFM_RST_BYTE;
      reg_addr <= `LFM_RST_BYTE;
      wr_data  <= `LFM_RST_BYTE;
      is_read  <= 1'b0;
      sda_oe   <= 1'b0;
      wr_stb   <= 1'b0;
      rd_stb   <= 1'b0;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else if (ce) begin
      state    <= next_state;
      cnt      <= next_cnt;
      shreg    <= next_shreg;
      reg_addr <= next_reg_addr;
      wr_data  <= next_wr_data;
      is_read  <= next_is_read;
      sda_oe   <= next_sda_oe;
      wr_stb   <= next_wr_stb;
      rd_stb   <= next_rd_stb;
      scl_q    <= scl;
      sda_q    <= sda_in;
    end
  end

endmodule

// >>> dv/lfm_fault_regs_chk.sv
// port checker for the fault block
// assumes binding to lfm_fault_regs, one clock domain
module lfm_fault_regs_chk #(
  parameter int CH_COUNT = 7
) (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       ce,
  input wire logic       ctrl_enable_b,
  input wire logic [6:0] ch_enabled,
  input wire logic [6:0] ch_undervolt,
  input wire logic [6:0] ch_overcurrent,
  input wire logic       rail_a_low,
  input wire logic       rail_b_low,
  input wire logic       rail_c_low,
  input wire logic       rail_d_low,
  input wire logic       ch7_rail_low,
  input wire logic       vsys_low,
  input wire logic       therm_shutdown,
  input wire logic       therm_warning,
  input wire logic       scl,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       fault_irq_pin_low_out,
  input wire logic       fault_irq_pin_low_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] rail_q;
  logic [3:0] fall_cnt;
  logic       scl_q;
  logic       rail_ev;
  logic       src;
  assign rail_ev = {rail_d_low, rail_c_low, rail_b_low, rail_a_low} != rail_q;
  assign src = rail_ev || |((ch_undervolt | ch_overcurrent) & ch_enabled);
  // ****************************************************************
  // helper state: rail edges and cycles since scl fell
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rail_q   <= 4'h0;
      scl_q    <= 1'b1;
      fall_cnt <= 4'hF;
    end else begin
      if (ce) begin
        rail_q <= {rail_d_low, rail_c_low, rail_b_low, rail_a_low};
      end
      scl_q <= scl;
      if (scl_q && !scl) begin
        fall_cnt <= 4'h0;
      end else if (fall_cnt != 4'hF) begin
        fall_cnt <= fall_cnt + 4'h1;
      end
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  sequence s_flag_set;
    rail_ev && ce && ctrl_enable_b;
  endsequence
  sequence s_quiet;
    (ctrl_enable_b && scl && ce) [*6];
  endsequence
  property p_pins_zero;
    !sda_out && !fault_irq_pin_low_out;
  endproperty
  a_pins_zero: assert property (p_pins_zero)
    else $error("open-drain output drives high");
  property p_rst_idle;
    disable iff (1'b0) !rst_b |=> !sda_oe && !fault_irq_pin_low_oe;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("pins not released in reset");
  property p_flag_irq;
    s_flag_set |-> ##[1:3] fault_irq_pin_low_oe;
  endproperty
  a_flag_irq: assert property (p_flag_irq)
    else $error("rail edge did not pull irq pin");
  property p_flag_hold;
    s_flag_set ##1 s_quiet |-> fault_irq_pin_low_oe;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("lockout flag dropped without clear");
  property p_flag_clear;
    (!ctrl_enable_b && !src && ce) [*4] |=> !fault_irq_pin_low_oe;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("irq pin held after enable clear");
  property p_irq_cause;
    $rose(fault_irq_pin_low_oe) |-> $past(src) || $past(src, 2) || $past(src, 3);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq pin pulled without cause");
  property p_oe_after_fall;
    // the driver moves in the cycle the fall is first seen, before fall_cnt leaves zero
    $changed(sda_oe) |-> fall_cnt == 4'h0;
  endproperty
  a_oe_after_fall: assert property (p_oe_after_fall)
    else $error("sda driver changed away from scl fall");
  property p_ce_hold;
    !ce [*2] |-> $stable(fault_irq_pin_low_oe) && $stable(sda_oe);
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("outputs moved while clock enable low");
endmodule

bind lfm_fault_regs lfm_fault_regs_chk #(.CH_COUNT(CH_COUNT)) i_chk (.*);

// >>> dv/lfm_host.sv
// i2c controller model standing for the host processor
// assumes an open-drain sda wire with pull-up built by the bench
module lfm_host #(
  parameter logic [6:0] DEV_ADDR = 7'h35
) (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  import lfm_pkg::*;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hp(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // start or repeated start when stop is 0, stop otherwise
  task automatic cond(input logic stop);
    sda_low <= stop;
    hp(4);
    scl <= 1'b1;
    hp(5);
    sda_low <= !stop;
    hp(5);
    if (!stop) begin
      scl <= 1'b0;
      hp(2);
    end
  endtask
  // eight bits then a released ninth bit
  task automatic xfer(input lfm_byte_t d, output lfm_byte_t q, output int ack);
    logic [8:0] s = {d, 1'b1};
    logic [8:0] r;
    for (int i = 8; i >= 0; i--) begin
      sda_low <= !s[i];
      hp(4);
      scl <= 1'b1;
      hp(5);
      r[i] = sda;
      scl <= 1'b0;
      hp(2);
    end
    q = r[8:1];
    ack = int'(!r[0]);
  endtask
  task automatic wr(input lfm_byte_t off, input lfm_byte_t d, output int acks);
    lfm_byte_t q;
    int        a;
    lfm_byte_t b [3] = '{{DEV_ADDR, 1'b0}, off, d};
    acks = 0;
    cond(1'b0);
    for (int i = 0; i < 3; i++) begin
      xfer(b[i], q, a);
      acks += a;
    end
    cond(1'b1);
  endtask
  task automatic rd(input lfm_byte_t off, output lfm_byte_t q, output int acks);
    int a;
    acks = 0;
    cond(1'b0);
    xfer({DEV_ADDR, 1'b0}, q, a);
    acks += a;
    xfer(off, q, a);
    acks += a;
    cond(1'b0);
    xfer({DEV_ADDR, 1'b1}, q, a);
    acks += a;
    xfer(8'hFF, q, a);
    cond(1'b1);
  endtask
endmodule

// >>> dv/lfm_fault_regs_tb.sv
// self-checking bench for the fault block
// assumes lfm_host as bus partner and the bound port checker
`include "lfm_map.svh"
`define CHK(nm, ex, sn) \
  begin \
    comparisons++; \
    if ((sn) !== (ex)) begin \
      num_errors++; \
      $display("MISMATCH %s exp %h got %h", nm, ex, sn); \
    end \
  end
module lfm_fault_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lfm_pkg::*;
  logic       mclk;
  logic       rst_b;
  logic       ce;
  logic       ctrl_enable_b;
  logic [6:0] ch_enabled;
  logic [6:0] ch_undervolt;
  logic [6:0] ch_overcurrent;
  logic [3:0] rails;
  logic       ch7_rail_low;
  logic       vsys_low;
  logic       therm_shutdown;
  logic       therm_warning;
  logic       scl;
  logic       host_low;
  logic       sda_out;
  logic       sda_oe;
  logic       irq_out;
  logic       irq_oe;
  wire logic  sda;
  wire logic  irq_n;
  int         num_errors;
  int         comparisons;
  // open-drain wires with pull-ups
  assign sda = !(sda_oe || host_low);
  assign irq_n = !irq_oe;
  lfm_fault_regs #(
    .CH_COUNT(7),
    .DEV_ADDR(`LFM_I2C_ADDR_DEFAULT)
  ) i_dut (
    .mclk, .rst_b, .ce, .ctrl_enable_b, .ch_enabled, .ch_undervolt, .ch_overcurrent,
    .rail_a_low(rails[0]), .rail_b_low(rails[1]), .rail_c_low(rails[2]),
    .rail_d_low(rails[3]), .ch7_rail_low, .vsys_low, .therm_shutdown, .therm_warning,
    .scl, .sda_in(sda), .sda_out, .sda_oe,
    .fault_irq_pin_low_out(irq_out), .fault_irq_pin_low_oe(irq_oe)
  );
  lfm_host #(.DEV_ADDR(`LFM_I2C_ADDR_DEFAULT)) i_host (.mclk, .sda, .scl, .sda_low(host_low));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ****************************************************************
  // bus and pin helpers
  // ****************************************************************
  task automatic rd_chk(input lfm_byte_t off, input lfm_byte_t ex);
    lfm_byte_t q;
    int        a;
    i_host.rd(off, q, a);
    `CHK("read ack", 3, a)
    `CHK("read data", ex, q)
  endtask
  task automatic wr(input lfm_byte_t off, input lfm_byte_t d);
    int a;
    i_host.wr(off, d, a);
    `CHK("write ack", 3, a)
  endtask
  task automatic irq_chk(input logic lvl);
    repeat (6) @(posedge mclk);
    `CHK("irq pin", lvl, irq_n)
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    for (int o = 8'h16; o <= 8'h1E; o++) begin
      rd_chk(8'(o), 8'h00);
    end
    irq_chk(1'b1);
    $display("test reset done");
  endtask
  task automatic t_status();
    logic [6:0] lv;
    lfm_byte_t  ex;
    for (int p = 0; p < 2; p++) begin
      @(posedge mclk);
      ch_enabled     <= p ? 7'h7F : 7'h5A;
      ch_undervolt   <= p ? 7'h00 : 7'h3C;
      ch_overcurrent <= p ? 7'h00 : 7'h66;
      rails          <= p ? 4'h0 : 4'hB;
      ch7_rail_low   <= p == 0;
      therm_shutdown <= p == 0;
      therm_warning  <= p == 0;
      vsys_low       <= p == 1;
      wr(`LFM_OFS_UV_STATUS, 8'hFF);
      lv = {ch7_rail_low, rails[3], rails[2], rails[1], rails[1], rails[0], rails[0]};
      rd_chk(`LFM_OFS_UV_STATUS, {1'b0, ch_undervolt & ch_enabled});
      rd_chk(`LFM_OFS_OC_STATUS, {1'b0, ch_overcurrent & ch_enabled});
      ex = {therm_shutdown, therm_warning, vsys_low, lv[6] & ch_enabled[6],
            lv[5] & ch_enabled[5], lv[4] & ch_enabled[4], rails[1] & |ch_enabled[3:2],
            rails[0] & |ch_enabled[1:0]};
      rd_chk(`LFM_OFS_THERM_STATUS, ex);
      ex = {therm_shutdown | vsys_low, (lv | ch_undervolt | ch_overcurrent) & ch_enabled};
      rd_chk(`LFM_OFS_SUSP_STATUS, ex);
    end
    $display("test status done");
  endtask
  task automatic t_flags();
    logic [3:0] seq [4] = '{4'h4, 4'h0, 4'hB, 4'hB};
    logic [3:0] prev = 4'h0;
    irq_chk(1'b0);
    ctrl_enable_b <= 1'b0;
    repeat (5) @(posedge mclk);
    ctrl_enable_b <= 1'b1;
    rd_chk(`LFM_OFS_LOCK_FLAGS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      rails <= seq[i];
      ch7_rail_low <= i == 3;
      irq_chk(seq[i] == prev);
      rd_chk(`LFM_OFS_LOCK_FLAGS, {4'h0, seq[i] ^ prev});
      rd_chk(`LFM_OFS_LOCK_FLAGS, 8'h00);
      irq_chk(1'b1);
      prev = seq[i];
    end
    $display("test flags done");
  endtask
  task automatic t_mask();
    @(posedge mclk);
    ch_undervolt <= 7'h01;
    irq_chk(1'b0);
    wr(`LFM_OFS_UV_MASK, 8'hFF);
    irq_chk(1'b1);
    rd_chk(`LFM_OFS_UV_MASK, 8'h7F);
    ch_overcurrent <= 7'h40;
    irq_chk(1'b0);
    wr(`LFM_OFS_OC_MASK, 8'h40);
    irq_chk(1'b1);
    rd_chk(`LFM_OFS_OC_MASK, 8'h40);
    wr(`LFM_OFS_UV_MASK, 8'h00);
    irq_chk(1'b0);
    ch_undervolt <= 7'h00;
    ch_overcurrent <= 7'h00;
    wr(`LFM_OFS_OC_MASK, 8'h00);
    irq_chk(1'b1);
    $display("test mask done");
  endtask
  task automatic t_ce();
    @(posedge mclk);
    ce <= 1'b0;
    rails <= 4'hA;
    irq_chk(1'b1);
    ce <= 1'b1;
    irq_chk(1'b0);
    rd_chk(`LFM_OFS_LOCK_FLAGS, 8'h01);
    $display("test clock enable done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    num_errors = 0;
    comparisons = 0;
    rst_b = 1'b0;
    ce = 1'b1;
    ctrl_enable_b = 1'b1;
    ch_enabled = 7'h00;
    ch_undervolt = 7'h00;
    ch_overcurrent = 7'h00;
    rails = 4'h0;
    ch7_rail_low = 1'b0;
    vsys_low = 1'b0;
    therm_shutdown = 1'b0;
    therm_warning = 1'b0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_status();
    t_flags();
    t_mask();
    t_ce();
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end
endmodule
